// [hdl/tmr_gate_pkg.sv]
// Package for the 16-bit timer control and gate block: offsets, fields, resets, types.
// Assumes a 32-bit APB slave with byte addresses; registers are up to 16 bits in the low lanes.
package tmr_gate_pkg;
  // Register byte addresses
  localparam logic [7:0] ctrl_addr = 8'h00;
  localparam logic [7:0] gctrl_addr = 8'h04;
  localparam logic [7:0] count_addr = 8'h08;
  localparam logic [7:0] irq_stat_addr = 8'h0c;
  localparam logic [7:0] irq_mask_addr = 8'h10;
  // Control register fields
  localparam int cs_lsb = 6;
  localparam int ps_lsb = 4;
  localparam int osc_en_bit = 3;
  localparam int sync_dis_bit = 2;
  localparam int run_bit = 0;
  localparam logic [7:0] ctrl_wmask = 8'hfd;
  // Gate control fields
  localparam int ge_bit = 7;
  localparam int gpol_bit = 6;
  localparam int gtm_bit = 5;
  localparam int gspm_bit = 4;
  localparam int ggo_bit = 3;
  localparam int gval_bit = 2;
  localparam int gss_lsb = 0;
  // Interrupt status bits
  localparam int irq_gate_bit = 0;
  localparam int irq_ovf_bit = 1;
  // Reset values
  localparam logic [7:0] ctrl_rst = 8'h00;
  localparam logic [7:0] gctrl_rst = 8'h00;
  localparam logic [1:0] irq_rst = 2'h0;
  // Clock source codes
  typedef enum logic [1:0] {
    src_instr = 2'b00, src_sys = 2'b01, src_ext = 2'b10, src_cap = 2'b11
  } clk_src_t;
  // External clock and gate inputs that travel together
  typedef struct packed {
    logic ext_clk;
    logic xtal_clk;
    logic cap_clk;
    logic [3:0] gate_src;
  } ext_in_t;
endpackage

// [hdl/tmr_gate.sv]
// 16-bit timer with clock source selection, prescaler and gate logic, APB registers.
// Assumes external clocks are slow versus mclk; every pin input is synchronised here.
// Operation
// - Source code 11 picks the cap-sense oscillator, 01 the system clock, 00 system clock / 4.
// - Source code 10 counts external pin rising edges, or the crystal when the oscillator is on.
// - Prescale codes 00..11 divide the selected clock by 1, 2, 4 or 8.
// - Control bit 3 switches the dedicated low-power oscillator on or off.
// - With source 1x counting is always synchronised; the sync-disable bit is stored but never read.
// - With source 0x the sync-disable bit is ignored.
// - Control bit 1 reads zero and ignores writes.
// - The run bit enables counting; clearing it stops the timer and clears the toggle flop.
// - Gate control holds enable, polarity, toggle, single-pulse, go/done, value, two-bit source.
// - In single-pulse mode the go/done bit set by software is cleared on gate value fall.
// - Toggle mode routes the gate through a flop toggling per rising edge of the polarised gate, else clear.
// - Each falling edge of the gate value sets the gate event flag, even without gating.
// - With run set, gate enable makes counting depend on the gate, else counting is free.
// - Gate polarity set counts while the gate is high, clear counts while it is low.
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ns
module tmr_gate (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire tmr_gate_pkg::ext_in_t ext_in,
  output logic low_power_osc_enable,
  output logic irq
);
  // Registers seen by software
  logic [7:0] ctrl_q;
  logic [7:0] gctrl_q;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_mask_q;
  logic [15:0] count_q;
  // Prescaler state; the third bit lives in ps_hi_q
  logic [1:0] ps_cnt_q;
  // Instruction clock divider
  logic [1:0] div4_q;
  // Pin synchronisers: two stages, the third only feeds edge detection
  logic [2:0] ext_s1_q;
  logic [2:0] ext_s2_q;
  logic [2:0] ext_s3_q;
  logic [3:0] gin_s1_q;
  logic [3:0] gin_s2_q;
  // Gate path state
  logic tog_q;
  logic gval_q;
  logic gpulse_q;
  // Bus strobes and per-register write decodes
  logic wr;
  logic rd;
  logic wr_ctrl;
  logic wr_gctrl;
  logic wr_count;
  logic wr_stat;
  logic wr_mask;
  // Counting path
  logic src_edge;
  logic inc;
  logic ovf;
  // Gate path
  logic gate_raw;
  logic gate_pol;
  logic gate_val;
  logic gate_fall;
  // Control fields and detected pin edges
  logic [1:0] cs;
  logic [1:0] ps;
  logic [2:0] ext_rise;
  // Write-one-to-clear requests for the sticky status bits
  logic [1:0] stat_clr;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign cs = ctrl_q[tmr_gate_pkg::cs_lsb +: 2];
  assign ps = ctrl_q[tmr_gate_pkg::ps_lsb +: 2];
  assign low_power_osc_enable = ctrl_q[tmr_gate_pkg::osc_en_bit];

  // Register write decodes; a write lands only in the access phase
  assign wr_ctrl = wr && hit(paddr, tmr_gate_pkg::ctrl_addr);
  assign wr_gctrl = wr && hit(paddr, tmr_gate_pkg::gctrl_addr);
  assign wr_count = wr && hit(paddr, tmr_gate_pkg::count_addr);
  assign wr_stat = wr && hit(paddr, tmr_gate_pkg::irq_stat_addr);
  assign wr_mask = wr && hit(paddr, tmr_gate_pkg::irq_mask_addr);
  // Ones written to the status register request a clear
  assign stat_clr = wr_stat ? pwdata[1:0] : 2'h0;

  // Two-flop synchronisers plus a third stage used only for edge detection
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ext_s1_q <= 3'h0;
      ext_s2_q <= 3'h0;
      ext_s3_q <= 3'h0;
      gin_s1_q <= 4'h0;
      gin_s2_q <= 4'h0;
    end else begin
      ext_s1_q[0] <= ext_in.ext_clk;
      ext_s1_q[1] <= ext_in.xtal_clk;
      ext_s1_q[2] <= ext_in.cap_clk;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
      gin_s1_q <= ext_in.gate_src;
      gin_s2_q <= gin_s1_q;
    end
  end
  assign ext_rise = ext_s2_q & ~ext_s3_q;

  // Instruction clock enable: one pulse every four system clocks
  // Free running, so the first tick after a write has an arbitrary phase
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      div4_q <= 2'h0;
    end else begin
      div4_q <= div4_q + 2'h1;
    end
  end

  // Source selection; a single clock domain forces synchronised counting, so the
  // sync-disable bit is never read and changes no edge timing
  always_comb begin
    unique case (tmr_gate_pkg::clk_src_t'(cs))
      tmr_gate_pkg::src_instr: src_edge = (div4_q == 2'h3);
      tmr_gate_pkg::src_sys: src_edge = 1'b1;
      tmr_gate_pkg::src_ext: begin
        if (ctrl_q[tmr_gate_pkg::osc_en_bit]) begin
          // Crystal path; sync-disable needs a second clock to matter, so the
          // synchronised edge is used either way
          src_edge = ext_rise[1];
        end else begin
          src_edge = ext_rise[0];
        end
      end
      tmr_gate_pkg::src_cap: src_edge = ext_rise[2];
    endcase
  end

  // Prescaler: count source edges and pass one in 1, 2, 4 or 8
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ps_cnt_q <= 2'h0;
    end else if (!ctrl_q[tmr_gate_pkg::run_bit]) begin
      ps_cnt_q <= 2'h0;
    end else if (src_edge) begin
      ps_cnt_q <= ps_cnt_q + 2'h1;
    end
  end

  // Prescaled tick; all four codes are legal, so no default
  logic ps_tick;
  always_comb begin
    unique case (ps)
      2'b00: ps_tick = src_edge;
      2'b01: ps_tick = src_edge && ps_cnt_q[0];
      2'b10: ps_tick = src_edge && (ps_cnt_q == 2'h1 || ps_cnt_q == 2'h3) && ps_cnt_q[1];
      2'b11: ps_tick = src_edge && (ps_cnt_q == 2'h3);
    endcase
  end

  // Divide-by-eight needs a third bit; it is carried in a separate flop
  logic ps_hi_q;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ps_hi_q <= 1'b0;
    end else if (!ctrl_q[tmr_gate_pkg::run_bit]) begin
      ps_hi_q <= 1'b0;
    end else if (src_edge && ps_cnt_q == 2'h3) begin
      ps_hi_q <= ~ps_hi_q;
    end
  end

  // The divide-by-eight tick also needs the high bit
  logic pre_tick;
  assign pre_tick = (ps == 2'b11) ? (ps_tick && ps_hi_q) : ps_tick;

  // Gate path: source pick, polarity, toggle flop, single-pulse qualifier
  assign gate_raw = gin_s2_q[gctrl_q[tmr_gate_pkg::gss_lsb +: 2]];
  assign gate_pol = gctrl_q[tmr_gate_pkg::gpol_bit] ? gate_raw : ~gate_raw;
  // Toggle flop flips on rising edges of the polarised gate; held clear while
  // toggle mode or the timer is off, so the measured edge is known
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tog_q <= 1'b0;
      gpulse_q <= 1'b0;
    end else if (!gctrl_q[tmr_gate_pkg::gtm_bit] || !ctrl_q[tmr_gate_pkg::run_bit]) begin
      tog_q <= 1'b0;
      gpulse_q <= gate_pol;
    end else begin
      gpulse_q <= gate_pol;
      if (gate_pol && !gpulse_q) begin
        tog_q <= ~tog_q;
      end
    end
  end

  logic gate_tm;
  assign gate_tm = gctrl_q[tmr_gate_pkg::gtm_bit] ? tog_q : gate_pol;
  // Single-pulse mode passes the gate only while go/done is armed
  always_comb begin
    gate_val = gate_tm;
    if (gctrl_q[tmr_gate_pkg::gspm_bit]) begin
      gate_val = gate_tm && gctrl_q[tmr_gate_pkg::ggo_bit];
    end
  end

  // Registered gate value, shown read-only in the gate control register
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      gval_q <= 1'b0;
    end else begin
      gval_q <= gate_val;
    end
  end
  // Falling edge of the gate value, seen one cycle before the register shows it
  assign gate_fall = gval_q && !gate_val;

  // Counter increments on prescaled ticks when running and the gate allows
  assign inc = ctrl_q[tmr_gate_pkg::run_bit] && pre_tick &&
    (!gctrl_q[tmr_gate_pkg::ge_bit] || gate_val);
  // Overflow marks the wrap from all ones
  assign ovf = inc && (count_q == 16'hffff);
  // A software write beats a same-cycle increment
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      count_q <= 16'h0000;
    end else if (wr_count) begin
      count_q <= pwdata[15:0];
    end else if (inc) begin
      count_q <= count_q + 16'h0001;
    end
  end

  // Control register; bit 1 is never stored
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= tmr_gate_pkg::ctrl_rst;
    end else if (wr_ctrl) begin
      // Writes to the spare bit are dropped by the mask
      ctrl_q <= pwdata[7:0] & tmr_gate_pkg::ctrl_wmask;
    end
  end

  // Gate control; go/done clears on gate value fall, and with single-pulse off
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      gctrl_q <= tmr_gate_pkg::gctrl_rst;
    end else begin
      if (wr_gctrl) begin
        gctrl_q[7:4] <= pwdata[7:4];
        gctrl_q[1:0] <= pwdata[1:0];
        // Go/done arms only with single-pulse set in the same write
        gctrl_q[tmr_gate_pkg::ggo_bit] <= pwdata[tmr_gate_pkg::ggo_bit] &&
          pwdata[tmr_gate_pkg::gspm_bit];
      end else if (gate_fall || !gctrl_q[tmr_gate_pkg::gspm_bit]) begin
        gctrl_q[tmr_gate_pkg::ggo_bit] <= 1'b0;
      end
      gctrl_q[tmr_gate_pkg::gval_bit] <= gval_q;
    end
  end

  // Sticky interrupt status: hardware set wins over a write-one clear
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irq_stat_q <= tmr_gate_pkg::irq_rst;
      irq_mask_q <= tmr_gate_pkg::irq_rst;
    end else begin
      if (wr_mask) begin
        irq_mask_q <= pwdata[1:0];
      end
      // Set terms come first so an event in the clear cycle is not lost
      irq_stat_q[tmr_gate_pkg::irq_gate_bit] <= gate_fall || (irq_stat_q[0] &&
        !stat_clr[0]);
      irq_stat_q[tmr_gate_pkg::irq_ovf_bit] <= ovf || (irq_stat_q[1] &&
        !stat_clr[1]);
    end
  end
  // Level output; it falls only when software clears or masks the bit
  assign irq = |(irq_stat_q & irq_mask_q);

  // Read data is registered in the setup cycle; unmapped addresses read zero
  // A read sees state one cycle before the access phase ends
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h0000_0000;
    end else if (rd) begin
      unique case (paddr)
        tmr_gate_pkg::ctrl_addr: prdata <= {24'h000000, ctrl_q};
        tmr_gate_pkg::gctrl_addr: prdata <= {24'h000000, gctrl_q};
        tmr_gate_pkg::count_addr: prdata <= {16'h0000, count_q};
        tmr_gate_pkg::irq_stat_addr: prdata <= {30'h0, irq_stat_q};
        tmr_gate_pkg::irq_mask_addr: prdata <= {30'h0, irq_mask_q};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule // tmr_gate

// [bench/tmr_gate_properties.sv]
// Port checker for the timer control and gate block: APB answers and readback.
// Assumes it is bound onto tmr_gate; read data is latched in the APB setup cycle.
`timescale 1ns/1ns
module tmr_gate_properties (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic low_power_osc_enable,
  input wire logic irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // Access phases, split by direction
  wire acc_w = psel && penable && pwrite;
  wire acc_r = psel && penable && !pwrite;
  wire ctl_w = acc_w && paddr == tmr_gate_pkg::ctrl_addr;
  ready_high_a: assert property (pready && !pslverr) else $error("bad APB answer");
  osc_write_a: assert property (ctl_w |=> low_power_osc_enable == $past(pwdata[3]))
    else $error("osc enable not loaded");
  osc_hold_a: assert property (!ctl_w |=> $stable(low_power_osc_enable))
    else $error("osc enable moved");
  ctrl_zero_a: assert property (acc_r && paddr == tmr_gate_pkg::ctrl_addr
    |-> prdata[31:8] == 24'h000000 && !prdata[1]) else $error("ctrl spare bits set");
  gctrl_upper_a: assert property (acc_r && paddr == tmr_gate_pkg::gctrl_addr
    |-> prdata[31:8] == 24'h000000) else $error("gate ctrl upper bits set");
  unmapped_zero_a: assert property (acc_r && paddr == 8'h14 |-> prdata == 32'h00000000)
    else $error("unmapped read not zero");
  ctrl_readback_a: assert property (ctl_w ##1 (psel && !penable && !pwrite
    && paddr == tmr_gate_pkg::ctrl_addr) |=> prdata[7:0] == ($past(pwdata[7:0], 2) & 8'hfd))
    else $error("ctrl readback wrong");
  go_refused_a: assert property ((acc_w && paddr == tmr_gate_pkg::gctrl_addr && !pwdata[4])
    ##1 (psel && !penable && !pwrite && paddr == tmr_gate_pkg::gctrl_addr) |=> !prdata[3])
    else $error("go bit stuck without single pulse");
  irq_masked_a: assert property (acc_w && paddr == tmr_gate_pkg::irq_mask_addr
    && pwdata[1:0] == 2'h0 |=> !irq) else $error("irq with mask clear");
  // Main scenarios reached
  cover property (irq);
  cover property (acc_w && paddr == tmr_gate_pkg::gctrl_addr && pwdata[4] && pwdata[3]);
  cover property (acc_r && paddr == tmr_gate_pkg::count_addr);
endmodule // tmr_gate_properties
bind tmr_gate tmr_gate_properties u_tmr_gate_properties (.mclk, .arst_n, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .low_power_osc_enable, .irq);

// [bench/tmr_gate_tb.sv]
// Self-checking bench for the timer control and gate block over APB.
// Assumes pready answers every access; count rates are exact once settled.
`timescale 1ns/1ns
module tmr_gate_tb;
  logic mclk, arst_n, psel, penable, pwrite, pready, pslverr, osc, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r, c1;
  logic [3:0] gsrc = 4'h0;
  logic [7:0] tick = 8'h00;
  int n_mismatch = 0;
  int samples_checked = 0;
  // ctrl, unused (gate ctrl written as 00), counts per 64 mclk
  logic [23:0] rows [12] = '{24'h410040, 24'h510020, 24'h610010, 24'h710008, 24'h010010,
    24'h310002, 24'h450040, 24'h810008, 24'h850008, 24'h890004, 24'hc10002, 24'h400000};
  tmr_gate_pkg::ext_in_t ext_in;
  // Free running pin clocks; slow enough for the input synchronisers
  assign ext_in = '{tick[2], tick[3], tick[4], gsrc};
  always @(posedge mclk) tick <= tick + 8'h01;
  tmr_gate u_tmr_gate (.mclk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .ext_in, .low_power_osc_enable(osc), .irq);
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // Caller must follow with another transfer or cyc so psel is released
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    r = prdata;
  endtask
  task cyc(input int n);
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (n) @(posedge mclk);
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Go bit only sticks with single pulse set; gate value bit is masked off
  function automatic logic [7:0] gexp(input logic [7:0] w);
    return (w & 8'h93) | {4'h0, w[4] & w[3], 3'h0};
  endfunction
  task stop_test;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    n_mismatch++;
    stop_test;
  end
  initial begin
    arst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 0;
    void'($urandom(1703));
    repeat (10) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 8'(i * 4), 0);
      check(r & ((i == 1) ? 32'hffff_fffb : 32'hffff_ffff), 0);
    end
    for (int i = 0; i < 8; i++) begin
      c1 = $urandom;
      apb(1'b1, tmr_gate_pkg::ctrl_addr, c1);
      apb(1'b0, tmr_gate_pkg::ctrl_addr, 0);
      check(r[7:0], c1[7:0] & 8'hfd);
      check(osc, c1[3]);
      c1 = $urandom & 32'h9b;
      apb(1'b1, tmr_gate_pkg::gctrl_addr, c1);
      apb(1'b0, tmr_gate_pkg::gctrl_addr, 0);
      check(r[7:0] & 8'hfb, gexp(c1[7:0]));
      apb(1'b1, 8'h14, $urandom);
    end
    for (int i = 0; i < 14; i++) begin
      c1 = i < 12 ? {8'h00, rows[i][23:16], 8'h00, rows[i][7:0]}
        : (i == 12 ? 32'hc0410000 : 32'h80410040);
      apb(1'b1, tmr_gate_pkg::ctrl_addr, c1[23:16]);
      apb(1'b1, tmr_gate_pkg::gctrl_addr, c1[31:24]);
      cyc(20);
      apb(1'b0, tmr_gate_pkg::count_addr, 0);
      c1[15:8] = r[7:0];
      c1[31:24] = r[15:8];
      cyc(62);
      apb(1'b0, tmr_gate_pkg::count_addr, 0);
      check(r[15:0] - {c1[31:24], c1[15:8]}, c1[7:0]);
    end
    apb(1'b1, tmr_gate_pkg::irq_mask_addr, 1);
    apb(1'b1, tmr_gate_pkg::irq_stat_addr, 3);
    cyc(1);
    for (int i = 0; i < 2; i++) begin
      gsrc <= 4'h1;
      cyc(10);
      gsrc <= 4'h0;
      cyc(10);
      if (i == 0) apb(1'b1, tmr_gate_pkg::gctrl_addr, 8'hd8);
      else apb(1'b0, tmr_gate_pkg::gctrl_addr, 0);
      if (i == 1) check(r[3], 1'b0);
      cyc(1);
    end
    check(irq, 1'b1);
    apb(1'b0, tmr_gate_pkg::irq_stat_addr, 0);
    check(r[0], 1'b1);
    apb(1'b1, tmr_gate_pkg::irq_stat_addr, 1);
    apb(1'b0, tmr_gate_pkg::irq_stat_addr, 0);
    check(r[0], 1'b0);
    apb(1'b1, tmr_gate_pkg::irq_mask_addr, 0);
    cyc(2);
    check(irq, 1'b0);
    stop_test;
  end
endmodule // tmr_gate_tb
